//--- rtl/pcf_ctl_flags.sv
`timescale 1ns/10ps
`default_nettype none
`include "pcf_defines.svh"
module pcf_ctl_flags
  import pcf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // privileged move port
  input wire logic mov_wr_i,
  input wire logic [1:0] mov_sel_i,
  input wire logic [31:0] mov_wdata_i,
  output logic [31:0] mov_rdata_o,
  output logic gp_fault_o,
  // core state
  input wire logic task_switch_i,
  input wire logic clr_ctx_switched_i,
  input wire logic user_align_flag_i,
  input wire logic [1:0] current_priv_level_i,
  input wire logic v86_mode_i,
  // decode request
  input wire logic dec_valid_i,
  input wire pcf_cls_t dec_cls_i,
  output logic no_fpu_fault_o,
  output logic bad_opcode_fault_o,
  output logic dec_exec_o,
  // floating-point error pins
  input wire logic fpu_err_i,
  input wire logic fpu_err_ignore_in_i,
  output logic fpu_err_out_o,
  output logic fpu_err_internal_o,
  output logic exec_halt_o,
  // derived control
  output logic protected_mode_o,
  output logic paging_active_o,
  output logic align_check_o,
  output logic sup_write_block_o,
  output logic normal_write_policy_o,
  output logic invalidate_en_o,
  output logic cache_restrict_o,
  output logic dir_nocache_o,
  output logic dir_write_thru_o,
  output logic v86_ext_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] sys_ctl_q;
  logic [31:0] dir_base_q;
  logic [31:0] ext_en_q;
  logic [31:0] sys_wdata;
  logic sys_wr;
  logic dir_wr;
  logic ext_wr;
  logic bad_paging;
  logic ts_reg;
  logic ts_next;
  pcf_state_t state_reg;
  pcf_state_t state_next;

  function automatic logic fbit(input logic [31:0] w, input int idx);
    fbit = w[idx[4:0]];
  endfunction : fbit

  assign bad_paging = mov_wdata_i[`PCF_BIT_PAGING_ON] & ~mov_wdata_i[`PCF_BIT_PROTECT_ON];
  assign sys_wr = mov_wr_i && (mov_sel_i == `PCF_SEL_SYS_CTL) && !bad_paging;
  assign dir_wr = mov_wr_i && (mov_sel_i == `PCF_SEL_DIR_BASE);
  assign ext_wr = mov_wr_i && (mov_sel_i == `PCF_SEL_EXT_EN);
  assign sys_wdata = mov_wdata_i;

  pcf_reg_word #(
    .WIDTH(32),
    .WMASK(`PCF_SYS_CTL_WMASK & ~(32'h1 << `PCF_BIT_FPU_CTX_SWITCHED)),
    .RESET(`PCF_SYS_CTL_RESET)
  ) u_sys_ctl (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_i(sys_wr),
    .wdata_i(sys_wdata),
    .q_o(sys_ctl_q)
  );

  pcf_reg_word #(
    .WIDTH(32),
    .WMASK(`PCF_DIR_BASE_WMASK),
    .RESET(`PCF_DIR_BASE_RESET)
  ) u_dir_base (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_i(dir_wr),
    .wdata_i(mov_wdata_i),
    .q_o(dir_base_q)
  );

  pcf_reg_word #(
    .WIDTH(32),
    .WMASK(`PCF_EXT_EN_WMASK),
    .RESET(`PCF_EXT_EN_RESET)
  ) u_ext_en (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_i(ext_wr),
    .wdata_i(mov_wdata_i),
    .q_o(ext_en_q)
  );

  // ----------------------------------------
  // task-switched flag
  // ----------------------------------------
  always_comb begin
    ts_next = ts_reg;
    if (sys_wr) begin
      ts_next = sys_wdata[`PCF_BIT_FPU_CTX_SWITCHED];
    end else if (clr_ctx_switched_i) begin
      ts_next = 1'b0;
    end
    if (task_switch_i) begin
      ts_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ts_reg <= 1'b0;
    end else begin
      ts_reg <= ts_next;
    end
  end

  logic pe;
  logic pg;
  logic cd;
  logic nw;
  logic em;
  logic mp;
  logic ne;
  assign pe = fbit(sys_ctl_q, `PCF_BIT_PROTECT_ON);
  assign pg = fbit(sys_ctl_q, `PCF_BIT_PAGING_ON);
  assign cd = fbit(sys_ctl_q, `PCF_BIT_CACHE_OFF);
  assign nw = fbit(sys_ctl_q, `PCF_BIT_NO_WRITEBACK);
  assign em = fbit(sys_ctl_q, `PCF_BIT_FPU_ABSENT);
  assign mp = fbit(sys_ctl_q, `PCF_BIT_WAIT_MONITOR);
  assign ne = fbit(sys_ctl_q, `PCF_BIT_NATIVE_FPU_ERROR);

  // ----------------------------------------
  // decode fault logic
  // ----------------------------------------
  logic nm_hit;
  logic ud_hit;
  always_comb begin
    nm_hit = 1'b0;
    ud_hit = 1'b0;
    case (dec_cls_i)
      PCF_CLS_FPU: nm_hit = em | ts_reg;
      PCF_CLS_WAIT: nm_hit = mp & ts_reg;
      PCF_CLS_MEDIA: begin
        ud_hit = em;
        nm_hit = ~em & ts_reg;
      end
      PCF_CLS_VEC: begin
        ud_hit = em;
        nm_hit = ~em & ts_reg;
      end
      default: begin
        nm_hit = 1'b0;
        ud_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // floating-point error handshake
  // ----------------------------------------
  logic is_fpu_op;
  assign is_fpu_op = dec_valid_i && (dec_cls_i == PCF_CLS_FPU || dec_cls_i == PCF_CLS_WAIT);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PCF_ST_RUN: begin
        if (fpu_err_i && !ne && !fpu_err_ignore_in_i) state_next = PCF_ST_FPU_ERR_OUT_PEND;
      end
      PCF_ST_FPU_ERR_OUT_PEND: begin
        if (fpu_err_ignore_in_i || ne) state_next = PCF_ST_RUN;
        else if (is_fpu_op) state_next = PCF_ST_HALT;
      end
      PCF_ST_HALT: begin
        if (fpu_err_ignore_in_i || ne) state_next = PCF_ST_RUN;
      end
      default: state_next = PCF_ST_RUN;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= PCF_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  logic halt_now;
  assign halt_now = (state_reg == PCF_ST_HALT) || (state_reg == PCF_ST_FPU_ERR_OUT_PEND && is_fpu_op);

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      no_fpu_fault_o <= 1'b0;
      bad_opcode_fault_o <= 1'b0;
      dec_exec_o <= 1'b0;
    end else begin
      no_fpu_fault_o <= dec_valid_i & nm_hit & ~ud_hit;
      bad_opcode_fault_o <= dec_valid_i & ud_hit;
      dec_exec_o <= dec_valid_i & ~nm_hit & ~ud_hit & ~halt_now;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fpu_err_out_o <= 1'b0;
      fpu_err_internal_o <= 1'b0;
      exec_halt_o <= 1'b0;
    end else begin
      fpu_err_out_o <= (state_next != PCF_ST_RUN);
      fpu_err_internal_o <= fpu_err_i & ne;
      exec_halt_o <= (state_next == PCF_ST_HALT);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mov_rdata_o <= 32'h00000000;
      gp_fault_o <= 1'b0;
    end else begin
      gp_fault_o <= mov_wr_i && (mov_sel_i == `PCF_SEL_SYS_CTL) && bad_paging;
      case (mov_sel_i)
        `PCF_SEL_SYS_CTL: begin
          mov_rdata_o <= sys_ctl_q;
          mov_rdata_o[`PCF_BIT_FPU_CTX_SWITCHED] <= ts_reg;
        end
        `PCF_SEL_DIR_BASE: mov_rdata_o <= dir_base_q;
        `PCF_SEL_EXT_EN: mov_rdata_o <= ext_en_q;
        default: mov_rdata_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      protected_mode_o <= 1'b0;
      paging_active_o <= 1'b0;
      align_check_o <= 1'b0;
      sup_write_block_o <= 1'b0;
      normal_write_policy_o <= 1'b0;
      invalidate_en_o <= 1'b0;
      cache_restrict_o <= 1'b0;
      dir_nocache_o <= 1'b0;
      dir_write_thru_o <= 1'b0;
      v86_ext_o <= 1'b0;
    end else begin
      protected_mode_o <= pe;
      paging_active_o <= pe & pg;
      align_check_o <= fbit(sys_ctl_q, `PCF_BIT_ALIGN_CHECK_EN) & user_align_flag_i
        & (current_priv_level_i == `PCF_USER_PRIV) & (pe | v86_mode_i);
      sup_write_block_o <= fbit(sys_ctl_q, `PCF_BIT_SUP_WRITE_GUARD);
      normal_write_policy_o <= ~nw & ~cd;
      invalidate_en_o <= ~nw & ~cd;
      cache_restrict_o <= cd;
      dir_nocache_o <= pe & pg & ~cd & fbit(dir_base_q, `PCF_BIT_DIR_NOCACHE);
      dir_write_thru_o <= pe & pg & ~cd & fbit(dir_base_q, `PCF_BIT_DIR_WRITE_THRU);
      v86_ext_o <= fbit(ext_en_q, `PCF_BIT_V86_EXT_ON);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_ext_kind_fixed: assert property (sys_ctl_q[`PCF_BIT_COPROC_EXT_KIND] == 1'b1)
    else $error("coproc_ext_kind not one");
  a_task_switch_sets: assert property (task_switch_i |=> ts_reg)
    else $error("task switch did not set flag");
  a_wait_fault: assert property (dec_valid_i && dec_cls_i == PCF_CLS_WAIT |=>
    no_fpu_fault_o == $past(mp & ts_reg))
    else $error("wait fault mismatch");
  a_fpu_absent_nm: assert property (dec_valid_i && dec_cls_i == PCF_CLS_FPU && em |=> no_fpu_fault_o)
    else $error("absent fpu op did not fault");
  a_media_ud: assert property (dec_valid_i && dec_cls_i == PCF_CLS_MEDIA && em |=>
    bad_opcode_fault_o && !no_fpu_fault_o)
    else $error("media op not bad opcode");
  a_vec_ts_nm: assert property (dec_valid_i && dec_cls_i == PCF_CLS_VEC && !em && ts_reg |=> no_fpu_fault_o)
    else $error("vector op with ctx switched did not fault");
  a_exempt_runs: assert property (dec_valid_i && dec_cls_i == PCF_CLS_VEC_EXEMPT && !halt_now |=>
    dec_exec_o && !no_fpu_fault_o && !bad_opcode_fault_o)
    else $error("exempt op faulted");
  a_em_masks_ts: assert property (dec_valid_i && em && dec_cls_i != PCF_CLS_WAIT |=>
    no_fpu_fault_o == $past(dec_cls_i == PCF_CLS_FPU))
    else $error("double fault under absent flag");
  a_paging_needs_pe: assert property (paging_active_o |-> $past(pe))
    else $error("paging active without protection");
  a_bad_paging_gp: assert property (mov_wr_i && mov_sel_i == `PCF_SEL_SYS_CTL && bad_paging |=>
    gp_fault_o && $stable(sys_ctl_q))
    else $error("paging without protection accepted");
  a_fpu_err_out_ignore: assert property (state_reg == PCF_ST_RUN && !ne && fpu_err_ignore_in_i |=> !fpu_err_out_o)
    else $error("error not ignored");
  a_fpu_err_out_assert: assert property (state_reg == PCF_ST_RUN && fpu_err_i && !ne && !fpu_err_ignore_in_i
    |=> fpu_err_out_o)
    else $error("fpu_err_out not raised");
  a_dir_ignored: assert property (cd |=> !dir_nocache_o && !dir_write_thru_o)
    else $error("directory flags honoured with cache off");

  c_task_switch: cover property (task_switch_i ##1 dec_valid_i && dec_cls_i == PCF_CLS_FPU);
  c_fpu_err_out_halt: cover property (state_reg == PCF_ST_FPU_ERR_OUT_PEND ##1 state_reg == PCF_ST_HALT);
  c_media_ud: cover property (bad_opcode_fault_o);
  c_gp: cover property (gp_fault_o);
endmodule : pcf_ctl_flags
`default_nettype wire

//--- rtl/pcf_reg_word.sv
`timescale 1ns/10ps
`default_nettype none
`include "pcf_defines.svh"
module pcf_reg_word #(
  parameter int WIDTH = 32,
  parameter logic [31:0] WMASK = 32'hffffffff,
  parameter logic [31:0] RESET = 32'h00000000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] q_o
);
  if (WIDTH != 32) begin : g_width_check
    $error("pcf_reg_word supports 32-bit words only");
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_o <= RESET;
    end else if (wr_i) begin
      q_o <= (wdata_i & WMASK) | (RESET & ~WMASK);
    end
  end
endmodule : pcf_reg_word
`default_nettype wire

//--- shared/pcf_defines.svh
`ifndef PCF_DEFINES_SVH
`define PCF_DEFINES_SVH
// ----------------------------------------
// register selects
// ----------------------------------------
`define PCF_SEL_SYS_CTL 2'h0
`define PCF_SEL_DIR_BASE 2'h1
`define PCF_SEL_EXT_EN 2'h2
// ----------------------------------------
// sys_ctl_main fields
// ----------------------------------------
`define PCF_BIT_PAGING_ON 31
`define PCF_BIT_CACHE_OFF 30
`define PCF_BIT_NO_WRITEBACK 29
`define PCF_BIT_ALIGN_CHECK_EN 18
`define PCF_BIT_SUP_WRITE_GUARD 16
`define PCF_BIT_NATIVE_FPU_ERROR 5
`define PCF_BIT_COPROC_EXT_KIND 4
`define PCF_BIT_FPU_CTX_SWITCHED 3
`define PCF_BIT_FPU_ABSENT 2
`define PCF_BIT_WAIT_MONITOR 1
`define PCF_BIT_PROTECT_ON 0
`define PCF_SYS_CTL_WMASK 32'he005002f
`define PCF_SYS_CTL_RESET 32'h00000010
// ----------------------------------------
// page_dir_base_reg fields
// ----------------------------------------
`define PCF_BIT_DIR_NOCACHE 4
`define PCF_BIT_DIR_WRITE_THRU 3
`define PCF_DIR_BASE_WMASK 32'hfffff018
`define PCF_DIR_BASE_RESET 32'h00000000
// ----------------------------------------
// ext_enable_reg fields and user privilege level
// ----------------------------------------
`define PCF_BIT_V86_EXT_ON 0
`define PCF_EXT_EN_WMASK 32'h00000001
`define PCF_EXT_EN_RESET 32'h00000000
`define PCF_USER_PRIV 2'h3
`endif

//--- shared/pcf_pkg.sv
package pcf_pkg;
  // instruction class presented for decode
  typedef enum logic [2:0] {
    PCF_CLS_NONE,
    PCF_CLS_FPU,
    PCF_CLS_WAIT,
    PCF_CLS_MEDIA,
    PCF_CLS_VEC,
    PCF_CLS_VEC_EXEMPT
  } pcf_cls_t;
  typedef enum logic [1:0] {
    PCF_ST_RUN,
    PCF_ST_FPU_ERR_OUT_PEND,
    PCF_ST_HALT
  } pcf_state_t;
endpackage : pcf_pkg

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pcf_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i, mov_wr_i, task_switch_i, clr_ctx_switched_i;
  logic user_align_flag_i, v86_mode_i, dec_valid_i, fpu_err_i, fpu_err_ignore_in_i;
  logic [1:0] mov_sel_i, current_priv_level_i;
  logic [31:0] mov_wdata_i, mov_rdata_o;
  pcf_cls_t dec_cls_i, ct;
  logic gp_fault_o, no_fpu_fault_o, bad_opcode_fault_o, dec_exec_o;
  logic fpu_err_out_o, fpu_err_internal_o, exec_halt_o, protected_mode_o;
  logic paging_active_o, align_check_o, sup_write_block_o, normal_write_policy_o;
  logic invalidate_en_o, cache_restrict_o, dir_nocache_o, dir_write_thru_o, v86_ext_o;
  logic nm, ud;
  int n_errors = 0;
  int tests_run = 0;
  int gp_cnt = 0;
  int g0;

  pcf_ctl_flags pcf_ctl_flags_inst (
    .clk_sys_i, .rst_i, .mov_wr_i, .mov_sel_i, .mov_wdata_i, .mov_rdata_o, .gp_fault_o,
    .task_switch_i, .clr_ctx_switched_i, .user_align_flag_i, .current_priv_level_i,
    .v86_mode_i, .dec_valid_i, .dec_cls_i, .no_fpu_fault_o, .bad_opcode_fault_o,
    .dec_exec_o, .fpu_err_i, .fpu_err_ignore_in_i, .fpu_err_out_o, .fpu_err_internal_o,
    .exec_halt_o, .protected_mode_o, .paging_active_o, .align_check_o, .sup_write_block_o,
    .normal_write_policy_o, .invalidate_en_o, .cache_restrict_o, .dir_nocache_o,
    .dir_write_thru_o, .v86_ext_o
  );

  // ----------------------------------------
  // clock, fault pulse count, watchdog
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (gp_fault_o === 1'b1) gp_cnt <= gp_cnt + 1;
  end

  initial begin
    #(25 * 4000);
    n_errors++;
    results();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task step;
    @(negedge clk_sys_i);
  endtask : step

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [1:0] s, input logic [31:0] d);
    mov_wr_i = 1'b1;
    mov_sel_i = s;
    mov_wdata_i = d;
    step();
    mov_wr_i = 1'b0;
  endtask : wr

  task rd(input logic [1:0] s, input logic [31:0] e);
    mov_sel_i = s;
    step();
    chk(mov_rdata_o, e);
  endtask : rd

  task dec(input pcf_cls_t c, input logic n, input logic u, input logic x);
    dec_valid_i = 1'b1;
    dec_cls_i = c;
    step();
    chk(no_fpu_fault_o, n);
    chk(bad_opcode_fault_o, u);
    chk(dec_exec_o, x);
  endtask : dec

  task results;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_i, mov_wr_i, task_switch_i, clr_ctx_switched_i} = 4'h8;
    {user_align_flag_i, v86_mode_i, dec_valid_i, fpu_err_i, fpu_err_ignore_in_i} = 5'h00;
    mov_sel_i = 2'h0;
    current_priv_level_i = 2'h0;
    mov_wdata_i = 32'h00000000;
    dec_cls_i = PCF_CLS_NONE;
    repeat (20) step();
    rst_i = 1'b0;
    // reset values and masks
    rd(2'h0, 32'h00000010);
    rd(2'h1, 32'h00000000);
    rd(2'h2, 32'h00000000);
    wr(2'h0, 32'hffffffff);
    rd(2'h0, 32'he005003f);
    wr(2'h0, 32'h00000000);
    rd(2'h0, 32'h00000010);
    wr(2'h3, 32'hffffffff);
    rd(2'h3, 32'h00000000);
    // paging without protection
    g0 = gp_cnt;
    wr(2'h0, 32'h80000000);
    step();
    step();
    chk(gp_cnt - g0, 32'h1);
    rd(2'h0, 32'h00000010);
    // alignment, write guard, mode
    for (int i = 0; i < 32; i++) begin
      user_align_flag_i = i[1];
      current_priv_level_i = i[2] ? 2'h3 : 2'h2;
      v86_mode_i = i[4];
      wr(2'h0, {13'h0, i[0], 1'b0, i[0], 15'h0, i[3]});
      step();
      chk(align_check_o, i[0] & i[1] & i[2] & (i[3] | i[4]));
      chk(sup_write_block_o, i[0]);
      chk(protected_mode_o, i[3]);
    end
    // cache policy and directory flags
    wr(2'h1, 32'hffffffff);
    rd(2'h1, 32'hfffff018);
    for (int i = 0; i < 4; i++) begin
      wr(2'h0, {1'b1, i[1], i[0], 28'h0, 1'b1});
      step();
      chk(paging_active_o, 1'b1);
      chk(cache_restrict_o, i[1]);
      chk(dir_nocache_o, !i[1]);
      chk(dir_write_thru_o, !i[1]);
      chk(normal_write_policy_o, i == 0);
      chk(invalidate_en_o, i == 0);
    end
    wr(2'h0, 32'h00000001);
    step();
    chk(paging_active_o, 1'b0);
    chk(dir_nocache_o, 1'b0);
    chk(dir_write_thru_o, 1'b0);
    // extension word
    wr(2'h2, 32'hffffffff);
    rd(2'h2, 32'h00000001);
    chk(v86_ext_o, 1'b1);
    wr(2'h2, 32'h00000000);
    step();
    chk(v86_ext_o, 1'b0);
    // decode table over all flag combinations
    for (int f = 0; f < 8; f++) begin
      wr(2'h0, {28'h0, f[0], f[2], f[1], 1'b1});
      for (int c = 0; c < 6; c++) begin
        ct = pcf_cls_t'(c);
        nm = (ct == PCF_CLS_FPU) ? (f[2] | f[0]) : (ct == PCF_CLS_WAIT) ? (f[1] & f[0]) :
             (ct == PCF_CLS_MEDIA || ct == PCF_CLS_VEC) ? (!f[2] & f[0]) : 1'b0;
        ud = (ct == PCF_CLS_MEDIA || ct == PCF_CLS_VEC) & f[2];
        dec(ct, nm, ud, !nm && !ud);
      end
      dec_valid_i = 1'b0;
    end
    // task switch sets, clear pulse drops
    wr(2'h0, 32'h00000001);
    task_switch_i = 1'b1;
    step();
    task_switch_i = 1'b0;
    rd(2'h0, 32'h00000019);
    dec(PCF_CLS_FPU, 1'b1, 1'b0, 1'b0);
    dec_valid_i = 1'b0;
    clr_ctx_switched_i = 1'b1;
    step();
    clr_ctx_switched_i = 1'b0;
    step();
    dec(PCF_CLS_FPU, 1'b0, 1'b0, 1'b1);
    dec_valid_i = 1'b0;
    // external error reporting and halt
    fpu_err_ignore_in_i = 1'b1;
    fpu_err_i = 1'b1;
    step();
    step();
    chk(fpu_err_out_o, 1'b0);
    fpu_err_ignore_in_i = 1'b0;
    step();
    step();
    chk(fpu_err_out_o, 1'b1);
    chk(fpu_err_internal_o, 1'b0);
    dec(PCF_CLS_FPU, 1'b0, 1'b0, 1'b0);
    dec_valid_i = 1'b0;
    step();
    chk(exec_halt_o, 1'b1);
    wr(2'h0, 32'h00000021);
    step();
    step();
    chk(fpu_err_internal_o, 1'b1);
    chk(exec_halt_o, 1'b0);
    chk(fpu_err_out_o, 1'b0);
    fpu_err_i = 1'b0;
    step();
    results();
  end
endmodule : testbench
`default_nettype wire
